// file: rtl/mrc_lock_timer.sv
// Purpose: lockout down-counter for reverse-channel direction changes
// Assumes: start pulses while ce is high
// Notes: restart reloads the full period
module mrc_lock_timer #(
   parameter logic [mrc_pkg::TMR_W-1:0] CYCLES =
      mrc_pkg::TMR_W'(mrc_pkg::LOCK_CYC)
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   mrc_tmr_if.tmr t
);
   logic [mrc_pkg::TMR_W-1:0] cnt_q;

   // ==========================================================
   // counter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= '0;
      end else if (ce) begin
         if (t.start) begin
            cnt_q <= CYCLES; // [RULE15] [RULE17]
         end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

   assign t.busy = (cnt_q != '0);

   a_lock_start: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && t.start |=> t.busy) // [RULE15]
      else $error("lockout did not start");
endmodule

// file: rtl/mrc_pkg.sv
// Purpose: constants and types for the modem rts/cts control block
// Assumes: 100 MHz aclk, AXI4-Lite register access, 32-bit data
// Notes: register offsets are byte addresses
// Functional notes
// RULE1: clear-to-send high enables transmitter clocks
// RULE2: cts drop mid-byte finishes byte, then marks
// RULE3: no rts switch closed keeps rts off
// RULE4: per-character mode wraps each character in rts
// RULE5: always-on mode holds rts high
// RULE6: extension unit may override rts directly
// RULE7: turnaround mode chooses code or reverse channel
// RULE8: one turnaround code, ETX or EOT only
// RULE9: turnaround code received latches code-seen flag
// RULE10: code-seen toggles direction after carrier falls
// RULE11: code while sending switches to receive immediately
// RULE12: secondary receive low forces receive, rts off
// RULE13: reverse receive copies carrier onto secondary transmit
// RULE14: secondary high, carrier low raises rts promptly
// RULE15: reverse-channel direction change starts 250 ms lockout
// RULE16: remote raises secondary receive to request transmit
// RULE17: all timing derived from the system clock
// RULE18: modem inputs synchronised before use
package mrc_pkg;
   // ==========================================================
   // register map
   localparam int ADDR_W = 4;
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] STAT_OFS = 4'h4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ==========================================================
   // control fields
   localparam int CTRL_W = 4;
   localparam int F_MODE_LO = 0;
   localparam int F_MODE_HI = 1;
   localparam int F_TREV = 2;
   localparam int F_EOT = 3;
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_CHAR = 2'h1;
   localparam logic [1:0] MODE_ON = 2'h2;
   localparam logic [1:0] MODE_TURN = 2'h3;
   localparam logic [7:0] CODE_ETX = 8'h03;
   localparam logic [7:0] CODE_EOT = 8'h04;
   // ==========================================================
   // status fields
   localparam int STAT_W = 8;
   localparam int S_CTS = 0;
   localparam int S_DCD = 1;
   localparam int S_SB = 2;
   localparam int S_RTS = 3;
   localparam int S_DIRTX = 4;
   localparam int S_SEEN = 5;
   localparam int S_LOCK = 6;
   localparam int S_TXEN = 7;
   // ==========================================================
   // timing
   localparam int CLK_KHZ = 100_000;
   localparam int LOCK_MS = 250;
   localparam int LOCK_CYC = LOCK_MS * CLK_KHZ;
   localparam int TMR_W = 25;
   typedef enum logic [1:0] {
      DIR_RX = 2'b01,
      DIR_TX = 2'b10
   } mrc_dir_e;
endpackage

// file: rtl/mrc_tmr_if.sv
// Purpose: link between direction control and lockout timer
// Assumes: single aclk domain
// Notes: start is a one-cycle pulse, busy a level
interface mrc_tmr_if;
   logic start;
   logic busy;
   modport ctl (output start, input busy);
   modport tmr (input start, output busy);
endinterface

// file: rtl/mrc_top.sv
// Purpose: modem rts/cts handshake control with AXI4-Lite registers
// Assumes: modem inputs asynchronous, transmitter signals synchronous
// Notes: ext_rts_en hands the rts pin to the extension port
module mrc_top #(
   parameter int unsigned LOCK_CYCLES = mrc_pkg::LOCK_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // axi4-lite slave
   input wire logic awvalid,
   output logic awready,
   input wire logic [mrc_pkg::ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [mrc_pkg::ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // modem side
   input wire logic cts_in,
   input wire logic dcd_in,
   input wire logic sec_rxd_in,
   input wire logic ext_rts_en,
   input wire logic ext_rts,
   output logic rts_out,
   output logic sec_txd_out,
   // transmitter and receive buffer side
   input wire logic tx_req,
   input wire logic tx_busy,
   input wire logic rx_strobe,
   input wire logic [7:0] rx_data,
   output logic tx_clk_en,
   output logic tx_go
);
   // ==========================================================
   // declarations
   logic aw_hold_q;
   logic w_hold_q;
   logic [mrc_pkg::ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic do_write;
   logic [mrc_pkg::CTRL_W-1:0] ctrl_q;
   logic [mrc_pkg::STAT_W-1:0] status;
   logic cts_m_q, cts_s_q;
   logic dcd_m_q, dcd_s_q;
   logic sb_m_q, sb_s_q;
   logic [1:0] mode;
   logic turn_code;
   logic turn_rev;
   logic [7:0] sel_code;
   logic code_hit;
   logic seen_q;
   mrc_pkg::mrc_dir_e dir_q, dir_d;
   logic rts_q, rts_d;
   logic sec_txd_q;
   logic txen_q;
   mrc_tmr_if tmr ();

   // ==========================================================
   // address decode
   function automatic logic [1:0] reg_hit(
      input logic [mrc_pkg::ADDR_W-1:0] a
   );
      reg_hit = {a == mrc_pkg::STAT_OFS, a == mrc_pkg::CTRL_OFS};
   endfunction

   // ==========================================================
   // write channels: address and data taken in either order
   assign awready = !aw_hold_q && !bvalid_q;
   assign wready = !w_hold_q && !bvalid_q;
   assign do_write = aw_hold_q && w_hold_q && !bvalid_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q <= 1'b0;
         awaddr_q <= '0;
      end else if (ce) begin
         if (awvalid && awready) begin
            aw_hold_q <= 1'b1;
            awaddr_q <= awaddr;
         end else if (do_write) begin
            aw_hold_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_hold_q <= 1'b0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else if (ce) begin
         if (wvalid && wready) begin
            w_hold_q <= 1'b1;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end else if (do_write) begin
            w_hold_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= mrc_pkg::RESP_OKAY;
      end else if (ce) begin
         if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= (reg_hit(awaddr_q) != 2'h0) ?
               mrc_pkg::RESP_OKAY : mrc_pkg::RESP_SLVERR;
         end else if (bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   assign bvalid = bvalid_q;
   assign bresp = bresp_q;

   // control register, low byte lane only carries fields
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= mrc_pkg::CTRL_RST;
      end else if (ce) begin
         if (do_write && reg_hit(awaddr_q) == 2'h1 && wstrb_q[0]) begin
            ctrl_q <= wdata_q[mrc_pkg::CTRL_W-1:0];
         end
      end
   end

   // ==========================================================
   // read channel
   assign arready = !rvalid_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= mrc_pkg::RESP_OKAY;
      end else if (ce) begin
         if (arvalid && arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= mrc_pkg::RESP_OKAY;
            unique case (reg_hit(araddr))
               2'h1: rdata_q <= {28'h0000000, ctrl_q};
               2'h2: rdata_q <= {24'h000000, status};
               default: begin
                  rdata_q <= '0;
                  rresp_q <= mrc_pkg::RESP_SLVERR;
               end
            endcase
         end else if (rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;

   // ==========================================================
   // modem input synchronisers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cts_m_q <= 1'b0;
         cts_s_q <= 1'b0;
         dcd_m_q <= 1'b0;
         dcd_s_q <= 1'b0;
         sb_m_q <= 1'b0;
         sb_s_q <= 1'b0;
      end else if (ce) begin
         cts_m_q <= cts_in; // [RULE18]
         cts_s_q <= cts_m_q;
         dcd_m_q <= dcd_in;
         dcd_s_q <= dcd_m_q;
         sb_m_q <= sec_rxd_in;
         sb_s_q <= sb_m_q;
      end
   end

   // ==========================================================
   // mode decode
   assign mode = ctrl_q[mrc_pkg::F_MODE_HI:mrc_pkg::F_MODE_LO];
   assign turn_code = (mode == mrc_pkg::MODE_TURN) &&
      !ctrl_q[mrc_pkg::F_TREV]; // [RULE7]
   assign turn_rev = (mode == mrc_pkg::MODE_TURN) &&
      ctrl_q[mrc_pkg::F_TREV]; // [RULE7]
   assign sel_code = ctrl_q[mrc_pkg::F_EOT] ?
      mrc_pkg::CODE_EOT : mrc_pkg::CODE_ETX; // [RULE8]
   assign code_hit = turn_code && rx_strobe &&
      (rx_data == sel_code); // [RULE8]

   // ==========================================================
   // transmitter clock gating
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         txen_q <= 1'b0;
      end else if (ce) begin
         // a byte in flight keeps its clocks, line then idles marking
         txen_q <= cts_s_q || tx_busy; // [RULE1] [RULE2]
      end
   end

   assign tx_clk_en = txen_q;
   assign tx_go = tx_req && txen_q &&
      ((mode != mrc_pkg::MODE_CHAR) || rts_q); // [RULE4]

   // ==========================================================
   // code-seen flag: a new code wins over its consumption
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         seen_q <= 1'b0;
      end else if (ce) begin
         if (!turn_code) begin
            seen_q <= 1'b0;
         end else if (code_hit && dir_q == mrc_pkg::DIR_RX) begin
            seen_q <= 1'b1; // [RULE9]
         end else if (dir_q == mrc_pkg::DIR_TX || !dcd_s_q) begin
            seen_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // direction state
   always_comb begin
      dir_d = dir_q;
      unique case (dir_q)
         mrc_pkg::DIR_RX: begin
            if (turn_code && seen_q && !dcd_s_q) begin
               dir_d = mrc_pkg::DIR_TX; // [RULE10]
            end
            if (turn_rev && sb_s_q && !dcd_s_q && !tmr.busy) begin
               dir_d = mrc_pkg::DIR_TX; // [RULE14] [RULE15] [RULE16]
            end
         end
         mrc_pkg::DIR_TX: begin
            if (code_hit) begin
               dir_d = mrc_pkg::DIR_RX; // [RULE11]
            end
            if (turn_rev && !sb_s_q) begin
               dir_d = mrc_pkg::DIR_RX; // [RULE12]
            end
         end
         default: dir_d = mrc_pkg::DIR_RX;
      endcase
      if (!turn_code && !turn_rev) begin
         dir_d = mrc_pkg::DIR_RX;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dir_q <= mrc_pkg::DIR_RX;
      end else if (ce) begin
         dir_q <= dir_d;
      end
   end

   // every reverse-channel turn starts the lockout
   assign tmr.start = ce && turn_rev && (dir_d != dir_q); // [RULE15]

   mrc_lock_timer #(
      .CYCLES(mrc_pkg::TMR_W'(LOCK_CYCLES))
   ) u_lock (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .t(tmr)
   );

   // ==========================================================
   // request-to-send and secondary transmit
   always_comb begin
      unique case (mode)
         mrc_pkg::MODE_OFF: rts_d = 1'b0; // [RULE3]
         mrc_pkg::MODE_CHAR: rts_d = tx_req || tx_busy; // [RULE4]
         mrc_pkg::MODE_ON: rts_d = 1'b1; // [RULE5]
         mrc_pkg::MODE_TURN: rts_d = (dir_d == mrc_pkg::DIR_TX);
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rts_q <= 1'b0;
      end else if (ce) begin
         rts_q <= rts_d;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sec_txd_q <= 1'b1;
      end else if (ce) begin
         if (turn_rev && dir_d == mrc_pkg::DIR_RX) begin
            sec_txd_q <= dcd_s_q; // [RULE13]
         end else begin
            sec_txd_q <= 1'b1;
         end
      end
   end

   // extension port may take the pin over
   assign rts_out = ext_rts_en ? ext_rts : rts_q; // [RULE6]
   assign sec_txd_out = sec_txd_q;

   // ==========================================================
   // status view
   always_comb begin
      status = '0;
      status[mrc_pkg::S_CTS] = cts_s_q;
      status[mrc_pkg::S_DCD] = dcd_s_q;
      status[mrc_pkg::S_SB] = sb_s_q;
      status[mrc_pkg::S_RTS] = rts_q;
      status[mrc_pkg::S_DIRTX] = (dir_q == mrc_pkg::DIR_TX);
      status[mrc_pkg::S_SEEN] = seen_q;
      status[mrc_pkg::S_LOCK] = tmr.busy;
      status[mrc_pkg::S_TXEN] = txen_q;
   end

   // ==========================================================
   // checks
   a_cts_clk_on: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && cts_s_q |=> txen_q) // [RULE1]
      else $error("cts high but transmit clocks off");

   a_byte_finish: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && tx_busy && !cts_s_q |=> txen_q) // [RULE2]
      else $error("clocks stopped mid byte");

   a_rts_off_mode: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && mode == mrc_pkg::MODE_OFF |=> !rts_q) // [RULE3]
      else $error("rts raised with all switches open");

   a_char_rts_first: assert property (@(posedge aclk)
      disable iff (!aresetn)
      ce && mode == mrc_pkg::MODE_CHAR && tx_req |=> rts_q) // [RULE4]
      else $error("rts not raised for pending character");

   a_char_rts_drop: assert property (@(posedge aclk)
      disable iff (!aresetn)
      ce && mode == mrc_pkg::MODE_CHAR && !tx_req && !tx_busy
      |=> !rts_q) // [RULE4]
      else $error("rts held after character left");

   a_rts_always: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && mode == mrc_pkg::MODE_ON |=> rts_q) // [RULE5]
      else $error("rts low in always-on mode");

   a_code_other: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && turn_code && !seen_q && dir_q == mrc_pkg::DIR_RX &&
      rx_strobe && rx_data != sel_code |=> !seen_q) // [RULE8]
      else $error("wrong code latched");

   a_code_latch: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && code_hit && dir_q == mrc_pkg::DIR_RX |=> seen_q) // [RULE9]
      else $error("turnaround code not latched");

   a_turn_wait: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && turn_code && dir_q == mrc_pkg::DIR_RX && dcd_s_q
      |=> dir_q == mrc_pkg::DIR_RX) // [RULE10]
      else $error("turned before carrier fell");

   a_turn_stop: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && code_hit && dir_q == mrc_pkg::DIR_TX
      |=> dir_q == mrc_pkg::DIR_RX) // [RULE11]
      else $error("code while sending did not stop");

   a_rev_sb_low: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && turn_rev && !sb_s_q |=> dir_q == mrc_pkg::DIR_RX && !rts_q)
      else $error("secondary low did not force receive"); // [RULE12]

   a_rev_sec_txd: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && turn_rev && dir_d == mrc_pkg::DIR_RX
      |=> sec_txd_q == $past(dcd_s_q)) // [RULE13]
      else $error("secondary transmit not following carrier");

   a_rev_turn_on: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && turn_rev && dir_q == mrc_pkg::DIR_RX && sb_s_q &&
      !dcd_s_q && !tmr.busy |=> rts_q) // [RULE14]
      else $error("rts not raised on reverse request");

   a_lock_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && turn_rev && tmr.busy && dir_q == mrc_pkg::DIR_RX
      |=> dir_q == mrc_pkg::DIR_RX) // [RULE15]
      else $error("direction changed during lockout");
endmodule

// file: tb/mrc_modem_model.sv
// Purpose: behavioural modem standing on the far side of the block
// Assumes: bench sets the wanted line levels, one clock domain
// Notes: DLY delays every line change by that many cycles (1 to 8)
module mrc_modem_model #(
   parameter int DLY = 1
) (
   input wire logic aclk,
   input wire logic want_cts,
   input wire logic want_dcd,
   input wire logic want_sb,
   output logic cts_in,
   output logic dcd_in,
   output logic sec_rxd_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] pipe_q [0:7];
   initial begin
      for (int i = 0; i < 8; i++) begin
         pipe_q[i] = 3'h0;
      end
   end
   // remote raises sb to ask the terminal to transmit
   always @(posedge aclk) begin
      pipe_q[0] <= {want_sb, want_dcd, want_cts};
      for (int i = 1; i < 8; i++) begin
         pipe_q[i] <= pipe_q[i-1];
      end
   end
   assign {sec_rxd_in, dcd_in, cts_in} = pipe_q[DLY-1];
endmodule

// file: tb/test_modem_rts_cts_control.sv
// Purpose: self-checking bench for the modem rts/cts control block
// Assumes: 100 MHz aclk, lockout shortened to 20 cycles
// Notes: bready and rready stay high for the whole run
module test_modem_rts_cts_control;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [3:0] CTRL = mrc_pkg::CTRL_OFS;
   localparam logic [3:0] STAT = mrc_pkg::STAT_OFS;
   logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
   logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic bready = 1'b1, rready = 1'b1;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
   logic [2:0] awprot = 3'h0, arprot = 3'h0;
   logic [31:0] wdata = 32'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, d;
   logic m_cts = 1'b0, m_dcd = 1'b1, m_sb = 1'b1;
   logic cts_in, dcd_in, sec_rxd_in, rts_out, sec_txd_out;
   logic ext_rts_en = 1'b0, ext_rts = 1'b0;
   logic tx_req = 1'b0, tx_busy = 1'b0, rx_strobe = 1'b0;
   logic [7:0] rx_data = 8'h0;
   logic tx_clk_en, tx_go;
   int error_cnt = 0, n_tests = 0;

   always #5 aclk = ~aclk;

   mrc_modem_model #(.DLY(2)) modem (.aclk, .want_cts(m_cts),
      .want_dcd(m_dcd), .want_sb(m_sb), .cts_in, .dcd_in, .sec_rxd_in);
   mrc_top #(.LOCK_CYCLES(20)) dut (
      .aclk, .aresetn, .ce, .awvalid, .awready, .awaddr, .awprot,
      .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
      .arvalid, .arready, .araddr, .arprot, .rvalid, .rready, .rdata,
      .rresp, .cts_in, .dcd_in, .sec_rxd_in, .ext_rts_en, .ext_rts,
      .rts_out, .sec_txd_out, .tx_req, .tx_busy, .rx_strobe, .rx_data,
      .tx_clk_en, .tx_go);

   // ==========================================================
   // checking and closing
   task automatic chk(input logic ok, input string m);
      n_tests++;
      if (ok !== 1'b1) begin
         $display("CHECK FAILED at %0t: %s", $time, m);
         error_cnt++;
      end
   endtask

   task automatic results();
      $display("mismatches %0d, checks %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ==========================================================
   // axi4-lite master, entered just after a rising edge
   task automatic wr(input logic [3:0] a, input logic [31:0] v,
         input logic [1:0] er);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid && n < 50);
      chk(bvalid === 1'b1 && bresp === er, "write response");
      if (bvalid !== 1'b1) results();
   endtask

   task automatic rd(input logic [3:0] a, input logic [1:0] er);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arready) arvalid <= 1'b0;
      end while (!rvalid && n < 50);
      d = rdata;
      chk(rvalid === 1'b1 && rresp === er, "read response");
      if (rvalid !== 1'b1) results();
   endtask

   // ==========================================================
   // pin helpers
   task automatic wt(input int s, input logic e, input int lim);
      logic v;
      int n;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         case (s)
            0: v = rts_out;
            1: v = tx_clk_en;
            2: v = sec_txd_out;
            default: v = tx_go;
         endcase
      end while (v !== e && n < lim);
      chk(v === e, "pin level wait");
      if (v !== e) results();
   endtask

   task automatic rx(input logic [7:0] c);
      rx_data <= c;
      rx_strobe <= 1'b1;
      @(posedge aclk);
      rx_strobe <= 1'b0;
      @(posedge aclk);
   endtask

   initial begin
      repeat (20000) @(posedge aclk);
      error_cnt++;
      results();
   end

   // ==========================================================
   // main sequence
   initial begin
      logic [7:0] c, o;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      chk(rts_out === 1'b0 && sec_txd_out === 1'b1, "reset pins");
      chk(tx_clk_en === 1'b0 && tx_go === 1'b0, "reset tx");
      rd(CTRL, 2'h0);
      chk(d === 32'h0, "ctrl reset");
      rd(4'h8, 2'h2);
      chk(d === 32'h0, "unmapped read");
      wr(4'hC, 32'hF, 2'h2);
      wr(STAT, 32'hFF, 2'h0);
      rd(STAT, 2'h0);
      chk(d === 32'h6, "status after reset");
      wstrb <= 4'hE;
      wr(CTRL, 32'h2, 2'h0);
      wstrb <= 4'hF;
      rd(CTRL, 2'h0);
      chk(d === 32'h0, "ctrl untouched");
      m_cts <= 1'b1;
      wt(1, 1'b1, 8);
      tx_busy <= 1'b1;
      m_cts <= 1'b0;
      repeat (8) @(posedge aclk);
      chk(tx_clk_en === 1'b1, "byte finishes");
      tx_busy <= 1'b0;
      wt(1, 1'b0, 4);
      tx_req <= 1'b1;
      repeat (4) @(posedge aclk);
      chk(tx_go === 1'b0, "no start without cts");
      m_cts <= 1'b1;
      wt(1, 1'b1, 8);
      repeat (3) @(posedge aclk);
      chk(rts_out === 1'b0, "off mode");
      tx_req <= 1'b0;
      wr(CTRL, 32'h1, 2'h0);
      chk(rts_out === 1'b0, "char idle");
      tx_req <= 1'b1;
      wt(0, 1'b1, 3);
      wt(3, 1'b1, 2);
      tx_req <= 1'b0;
      tx_busy <= 1'b1;
      repeat (4) @(posedge aclk);
      chk(rts_out === 1'b1, "char hold");
      tx_busy <= 1'b0;
      wt(0, 1'b0, 3);
      wr(CTRL, 32'h2, 2'h0);
      wt(0, 1'b1, 3);
      ext_rts_en <= 1'b1;
      repeat (2) @(posedge aclk);
      chk(rts_out === 1'b0, "extension override");
      ext_rts_en <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         c = k ? mrc_pkg::CODE_EOT : mrc_pkg::CODE_ETX;
         o = k ? mrc_pkg::CODE_ETX : mrc_pkg::CODE_EOT;
         m_dcd <= 1'b1;
         wr(CTRL, {28'h0, k[0], 3'h3}, 2'h0);
         rx(o);
         rd(STAT, 2'h0);
         chk(d[5] === 1'b0, "other code ignored");
         rx(c);
         rd(STAT, 2'h0);
         chk(d[5:4] === 2'h2 && rts_out === 1'b0, "code seen");
         m_dcd <= 1'b0;
         wt(0, 1'b1, 10);
         m_dcd <= 1'b1;
         rx(c);
         wt(0, 1'b0, 3);
      end
      wr(CTRL, 32'h7, 2'h0);
      m_sb <= 1'b0;
      m_dcd <= 1'b0;
      wt(2, 1'b0, 10);
      chk(rts_out === 1'b0, "reverse receive");
      m_dcd <= 1'b1;
      wt(2, 1'b1, 10);
      m_sb <= 1'b1;
      repeat (30) @(posedge aclk);
      chk(rts_out === 1'b0, "carrier still up");
      m_dcd <= 1'b0;
      wt(0, 1'b1, 10);
      m_sb <= 1'b0;
      wt(0, 1'b0, 6);
      m_sb <= 1'b1;
      for (int i = 0; i < 12; i++) begin
         @(posedge aclk);
         chk(rts_out === 1'b0, "lockout holds");
      end
      wt(0, 1'b1, 20);
      ce <= 1'b0;
      m_sb <= 1'b0;
      repeat (8) @(posedge aclk);
      chk(rts_out === 1'b1, "clock enable freezes state");
      ce <= 1'b1;
      wt(0, 1'b0, 8);
      ext_rts <= 1'b1;
      ext_rts_en <= 1'b1;
      repeat (2) @(posedge aclk);
      chk(rts_out === 1'b1, "extension drives rts high");
      results();
   end
endmodule
